/* File: common/nfsp_params.svh */
// Constants for the serial NAND setting and status logic
// Assumes one inclusion per compile unit; guarded below
`ifndef NFSP_PARAMS_SVH
`define NFSP_PARAMS_SVH
// Setting register addresses
`define NFSP_ADDR_PROT   8'hA0
`define NFSP_ADDR_CFG    8'hB0
`define NFSP_ADDR_STS    8'hC0
// Command opcodes
`define NFSP_OP_GET      8'h0F
`define NFSP_OP_SET      8'h1F
`define NFSP_OP_WREN     8'h06
`define NFSP_OP_WRDI     8'h04
`define NFSP_OP_RESET    8'hFF
`define NFSP_OP_PROG     8'h10
`define NFSP_OP_ERASE    8'hD8
`define NFSP_OP_READ     8'h13
// Frame lengths in link clock edges
`define NFSP_LEN_OP      6'h08
`define NFSP_LEN_GET     6'h10
`define NFSP_LEN_SET     6'h18
`define NFSP_LEN_ROW     6'h20
`define NFSP_LEN_MAX     6'h28
// Reset values
`define NFSP_PROT_RST    8'h7C
`define NFSP_CFG_RST     8'h10
`define NFSP_STS_RST     8'h00
// Protection register fields
`define NFSP_PR_GUARD_A  7
`define NFSP_PR_CODE_HI  6
`define NFSP_PR_CODE_LO  3
`define NFSP_PR_BOTTOM   2
`define NFSP_PR_GUARD_B  0
// Configuration register fields
`define NFSP_CF_OTPP     7
`define NFSP_CF_OTPE     6
`define NFSP_CF_FREEZE   5
`define NFSP_CF_ECCE     4
// Status register fields
`define NFSP_ST_ECC_HI   5
`define NFSP_ST_ECC_LO   4
`define NFSP_ST_PFAIL    3
`define NFSP_ST_EFAIL    2
`define NFSP_ST_WEL      1
`define NFSP_ST_BUSY     0
// Timing: reset command busy time when idle
`define NFSP_CLK_NS      100
`define NFSP_T_RST_NS    5000
`define NFSP_RST_CYC     (`NFSP_T_RST_NS / `NFSP_CLK_NS)
`endif

/* File: common/nfsp_pkg.sv */
// Types shared by the serial NAND setting and status logic
// Assumes the constants header is compiled alongside
package nfsp_pkg;
    // Core sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_BOOT  = 4'h2,
        ST_ARRAY = 4'h4,
        ST_RESET = 4'h8
    } nfsp_state_t;

    // Command word handed from the link to the core
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] arg;
    } nfsp_cmd_t;

    // Register snapshot handed from the core to the link
    typedef struct packed {
        logic [7:0] prot;
        logic [7:0] cfg;
        logic [7:0] sts;
    } nfsp_snap_t;
endpackage

/* File: rtl/nfsp_top.sv */
// Setting, protection and status logic of a serial NAND device
// Assumes a mode 0/3 serial host on the link pins and an array
// controller on clock_i that answers each start with arr_done_i
//
// Operation
// - Four-bit code selects locked array fraction
// - Select bit zero locks from top blocks
// - Select bit one locks from block zero
// - Locked program or erase leaves array untouched
// - Correction enable bit steers array operations
// - Freeze needs both guard bits; freezes protection
// - OTP enable and correction enable are volatile
// - OTP bit pair selects array access mode
// - Status readable anytime via read setting command
// - Failed, locked or out-of-range program sets program fail
// - Program command and reset clear program fail
// - Failed or locked erase sets erase fail
// - Erase command and reset clear erase fail
// - Write enable and disable drive the latch
// - Busy flag high while operation executes
// - Correction result cleared at reset, read start
// - Correction result encoding zero, one, two
// - Power-up reads block zero page zero
// - Read and write setting commands with address
// - Reset command keeps settings intact
`timescale 1ns/1ps
`include "nfsp_params.svh"

module nfsp_top
    import nfsp_pkg::*;
#(
    parameter int BLK_W = 10,
    parameter int PAGE_W = 6
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    output logic             arr_prog_o,
    output logic             arr_erase_o,
    output logic             arr_read_o,
    output logic [23:0]      arr_row_o,
    output logic             arr_ecc_en_o,
    output logic [1:0]       otp_mode_o,
    input  wire logic        arr_done_i,
    input  wire logic        arr_fail_i,
    input  wire logic [1:0]  arr_ecc_result_i
);

    // Elaboration guard: fraction decode needs at least 512 blocks
    if (BLK_W < 9 || BLK_W + PAGE_W > 23) begin : g_bad_width
        $error("nfsp_top: unsupported block or page width");
    end

    localparam logic [15:0] RST_CYC = 16'(`NFSP_RST_CYC);

    // Locked-range decode for one block address
    function automatic logic lock_hit(input logic [3:0] code, input logic bottom,
                                      input logic [BLK_W-1:0] blk);
        logic [BLK_W:0] full;
        logic [BLK_W:0] sz;
        full = {1'b1, {BLK_W{1'b0}}};
        sz   = full >> (4'hA - code);
        if (code == 4'h0) begin
            lock_hit = 1'b0;
        end else if (code >= 4'hA) begin
            lock_hit = 1'b1;
        end else if (bottom) begin
            lock_hit = ({1'b0, blk} < sz);
        end else begin
            lock_hit = ({1'b0, blk} >= (full - sz));
        end
    endfunction

    // Frame length for an opcode, zero when nothing is handed over
    function automatic logic [5:0] frame_len(input logic [7:0] op);
        case (op)
            `NFSP_OP_WREN, `NFSP_OP_WRDI, `NFSP_OP_RESET: frame_len = `NFSP_LEN_OP;
            `NFSP_OP_SET: frame_len = `NFSP_LEN_SET;
            `NFSP_OP_PROG, `NFSP_OP_ERASE, `NFSP_OP_READ: frame_len = `NFSP_LEN_ROW;
            default: frame_len = 6'h00;
        endcase
    endfunction

    // Link-side state, all on spi_sck_i
    logic [5:0]  cnt_q, cnt_d;
    logic [23:0] sh_q, sh_d;
    logic [7:0]  op_q, op_d;
    logic [7:0]  tx_q, tx_d;
    logic        tx_act_q, tx_act_d;
    logic        ps1_q, ps2_q, seen_q, seen_d;
    nfsp_snap_t  shadow_q, shadow_d;
    nfsp_cmd_t   cmd_q, cmd_d;
    logic        req_q, req_d;
    logic        miso_q, miso_oe_q;

    // Core-side state, all on clock_i
    nfsp_state_t state_q, state_d;
    logic [7:0]  prot_q, prot_d;
    logic [7:0]  cfg_q, cfg_d;
    logic [7:0]  sts_q, sts_d;
    logic [7:0]  act_op_q, act_op_d;
    logic [23:0] row_q, row_d;
    logic [15:0] tmr_q, tmr_d;
    logic        prog_q, prog_d, erase_q, erase_d, read_q, read_d;
    logic        rs1_q, rs2_q, rs3_q;
    logic        as1_q, as2_q;
    nfsp_snap_t  pub_q, pub_d;
    logic        pub_tgl_q, pub_tgl_d;

    logic [7:0]  byte_in;
    logic        cmd_ev;
    logic        hit;
    logic        bad_row;

    // Link next values; frame logic restarts on every select
    always_comb begin
        byte_in  = {sh_q[6:0], spi_mosi_i};
        cnt_d    = (cnt_q == `NFSP_LEN_MAX) ? cnt_q : cnt_q + 6'h01;
        sh_d     = {sh_q[22:0], spi_mosi_i};
        op_d     = (cnt_q == 6'h07) ? byte_in : op_q;
        tx_d     = {tx_q[6:0], 1'b0};
        tx_act_d = tx_act_q;
        shadow_d = shadow_q;
        seen_d   = seen_q;
        cmd_d    = cmd_q;
        req_d    = req_q;
        // Take a fresh snapshot only once the core holds it still
        if (ps2_q != seen_q) begin
            shadow_d = pub_q;
            seen_d   = ps2_q;
        end
        // addressed register byte loaded after the address byte
        if (op_q == `NFSP_OP_GET && cnt_d == `NFSP_LEN_GET) begin
            tx_act_d = 1'b1;
            case (byte_in)
                `NFSP_ADDR_PROT: tx_d = shadow_q.prot;
                `NFSP_ADDR_CFG:  tx_d = shadow_q.cfg;
                `NFSP_ADDR_STS:  tx_d = shadow_q.sts;
                default:         tx_d = 8'h00;
            endcase
        end
        // hand a complete command over by toggle
        if (frame_len(op_d) != 6'h00 && cnt_d == frame_len(op_d) && cnt_q != `NFSP_LEN_MAX) begin
            cmd_d.op  = op_d;
            cmd_d.arg = sh_d;
            req_d     = ~req_q;
        end
    end

    // Frame registers, cleared while the host deselects
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            cnt_q    <= 6'h00;
            sh_q     <= 24'h000000;
            op_q     <= 8'h00;
            tx_q     <= 8'h00;
            tx_act_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            sh_q     <= sh_d;
            op_q     <= op_d;
            tx_q     <= tx_d;
            tx_act_q <= tx_act_d;
        end
    end

    // Persistent link registers; the link clock may stop, so reset is asynchronous here
    always_ff @(posedge spi_sck_i or posedge rst_i) begin
        if (rst_i) begin
            ps1_q    <= 1'b0;
            ps2_q    <= 1'b0;
            seen_q   <= 1'b0;
            shadow_q <= '0;
            cmd_q    <= '0;
            req_q    <= 1'b0;
        end else begin
            ps1_q    <= pub_tgl_q;
            ps2_q    <= ps1_q;
            seen_q   <= seen_d;
            shadow_q <= shadow_d;
            cmd_q    <= cmd_d;
            req_q    <= req_d;
        end
    end

    // Output bit changes on the falling edge so the host samples it settled
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            miso_q    <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            miso_q    <= tx_q[7];
            miso_oe_q <= tx_act_q;
        end
    end

    assign spi_miso_o    = miso_q;
    assign spi_miso_oe_o = miso_oe_q;

    // Core next values
    always_comb begin
        cmd_ev    = rs2_q ^ rs3_q;
        bad_row   = (cmd_q.arg[23:BLK_W+PAGE_W] != '0);
        // range decode of the addressed block
        hit       = lock_hit(prot_q[`NFSP_PR_CODE_HI:`NFSP_PR_CODE_LO], prot_q[`NFSP_PR_BOTTOM],
                             cmd_q.arg[PAGE_W +: BLK_W]);
        state_d   = state_q;
        prot_d    = prot_q;
        cfg_d     = cfg_q;
        sts_d     = sts_q;
        act_op_d  = act_op_q;
        row_d     = row_q;
        tmr_d     = tmr_q;
        prog_d    = 1'b0;
        erase_d   = 1'b0;
        read_d    = 1'b0;
        pub_d     = pub_q;
        pub_tgl_d = pub_tgl_q;
        case (state_q)
            // power-up read of block zero page zero
            ST_BOOT: begin
                read_d   = 1'b1;
                row_d    = 24'h000000;
                act_op_d = `NFSP_OP_READ;
                sts_d[`NFSP_ST_ECC_HI:`NFSP_ST_ECC_LO] = 2'h0;
                state_d  = ST_ARRAY;
            end
            ST_ARRAY: begin
                if (arr_done_i) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (tmr_q == 16'h0000) begin
                    state_d = ST_IDLE;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            ST_IDLE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (cmd_ev) begin
            case (cmd_q.op)
                `NFSP_OP_SET: begin
                    // protection register frozen once the freeze bit is set
                    if (cmd_q.arg[15:8] == `NFSP_ADDR_PROT && !cfg_q[`NFSP_CF_FREEZE]) begin
                        prot_d = cmd_q.arg[7:0];
                    end
                    if (cmd_q.arg[15:8] == `NFSP_ADDR_CFG) begin
                        cfg_d[`NFSP_CF_OTPE] = cmd_q.arg[`NFSP_CF_OTPE];
                        cfg_d[`NFSP_CF_ECCE] = cmd_q.arg[`NFSP_CF_ECCE];
                        // OTP lock only with enable; no command clears it again
                        cfg_d[`NFSP_CF_OTPP] = cfg_q[`NFSP_CF_OTPP]
                                             | (cmd_q.arg[`NFSP_CF_OTPP] & cmd_q.arg[`NFSP_CF_OTPE]);
                        // freeze accepted only with both guard bits set
                        cfg_d[`NFSP_CF_FREEZE] = cfg_q[`NFSP_CF_FREEZE] | (cmd_q.arg[`NFSP_CF_FREEZE]
                                               & prot_q[`NFSP_PR_GUARD_A] & prot_q[`NFSP_PR_GUARD_B]);
                    end
                end
                `NFSP_OP_WREN: sts_d[`NFSP_ST_WEL] = 1'b1;
                `NFSP_OP_WRDI: sts_d[`NFSP_ST_WEL] = 1'b0;
                // reset clears status only, settings stay
                `NFSP_OP_RESET: begin
                    sts_d[`NFSP_ST_PFAIL] = 1'b0;
                    sts_d[`NFSP_ST_EFAIL] = 1'b0;
                    sts_d[`NFSP_ST_ECC_HI:`NFSP_ST_ECC_LO] = 2'h0;
                    tmr_d   = RST_CYC - 16'h0001;
                    state_d = ST_RESET;
                end
                `NFSP_OP_PROG: begin
                    if (state_q == ST_IDLE) begin
                        sts_d[`NFSP_ST_PFAIL] = 1'b0;
                        if (!sts_q[`NFSP_ST_WEL]) begin
                            sts_d[`NFSP_ST_PFAIL] = 1'b0;
                        end else if (hit || bad_row) begin
                            sts_d[`NFSP_ST_PFAIL] = 1'b1;
                        end else begin
                            prog_d   = 1'b1;
                            row_d    = cmd_q.arg;
                            act_op_d = `NFSP_OP_PROG;
                            state_d  = ST_ARRAY;
                        end
                    end
                end
                `NFSP_OP_ERASE: begin
                    if (state_q == ST_IDLE) begin
                        sts_d[`NFSP_ST_EFAIL] = 1'b0;
                        if (!sts_q[`NFSP_ST_WEL]) begin
                            sts_d[`NFSP_ST_EFAIL] = 1'b0;
                        end else if (hit) begin
                            sts_d[`NFSP_ST_EFAIL] = 1'b1;
                        end else begin
                            erase_d  = 1'b1;
                            row_d    = cmd_q.arg;
                            act_op_d = `NFSP_OP_ERASE;
                            state_d  = ST_ARRAY;
                        end
                    end
                end
                `NFSP_OP_READ: begin
                    if (state_q == ST_IDLE) begin
                        sts_d[`NFSP_ST_ECC_HI:`NFSP_ST_ECC_LO] = 2'h0;
                        read_d   = 1'b1;
                        row_d    = cmd_q.arg;
                        act_op_d = `NFSP_OP_READ;
                        state_d  = ST_ARRAY;
                    end
                end
                default: begin
                    sts_d = sts_d;
                end
            endcase
        end
        // completion results; a fail set here beats any clear above, a reset command beats the correction result
        if (state_q == ST_ARRAY && arr_done_i) begin
            if (act_op_q == `NFSP_OP_PROG && arr_fail_i) begin
                sts_d[`NFSP_ST_PFAIL] = 1'b1;
            end
            if (act_op_q == `NFSP_OP_ERASE && arr_fail_i) begin
                sts_d[`NFSP_ST_EFAIL] = 1'b1;
            end
            if (act_op_q == `NFSP_OP_READ && !(cmd_ev && cmd_q.op == `NFSP_OP_RESET)) begin
                sts_d[`NFSP_ST_ECC_HI:`NFSP_ST_ECC_LO] = arr_ecc_result_i;
            end
        end
        sts_d[`NFSP_ST_BUSY] = (state_d != ST_IDLE);
        sts_d[7:6] = 2'h0;
        cfg_d[3:0] = 4'h0;
        // Publish a new snapshot once the link has taken the last one
        if (as2_q == pub_tgl_q) begin
            pub_d.prot = prot_q;
            pub_d.cfg  = cfg_q;
            pub_d.sts  = sts_q;
            pub_tgl_d  = ~pub_tgl_q;
        end
    end

    // Core registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q   <= ST_BOOT;
            prot_q    <= `NFSP_PROT_RST;
            cfg_q     <= `NFSP_CFG_RST;
            sts_q     <= `NFSP_STS_RST;
            act_op_q  <= 8'h00;
            row_q     <= 24'h000000;
            tmr_q     <= 16'h0000;
            prog_q    <= 1'b0;
            erase_q   <= 1'b0;
            read_q    <= 1'b0;
            rs1_q     <= 1'b0;
            rs2_q     <= 1'b0;
            rs3_q     <= 1'b0;
            as1_q     <= 1'b0;
            as2_q     <= 1'b0;
            pub_q     <= '0;
            pub_tgl_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            prot_q    <= prot_d;
            cfg_q     <= cfg_d;
            sts_q     <= sts_d;
            act_op_q  <= act_op_d;
            row_q     <= row_d;
            tmr_q     <= tmr_d;
            prog_q    <= prog_d;
            erase_q   <= erase_d;
            read_q    <= read_d;
            rs1_q     <= req_q;
            rs2_q     <= rs1_q;
            rs3_q     <= rs2_q;
            as1_q     <= seen_q;
            as2_q     <= as1_q;
            pub_q     <= pub_d;
            pub_tgl_q <= pub_tgl_d;
        end
    end

    // Array-facing outputs, all registered
    assign arr_prog_o   = prog_q;
    assign arr_erase_o  = erase_q;
    assign arr_read_o   = read_q;
    assign arr_row_o    = row_q;
    // correction enable passed to the array
    assign arr_ecc_en_o = cfg_q[`NFSP_CF_ECCE];
    // access mode straight from the OTP bit pair
    assign otp_mode_o   = cfg_q[`NFSP_CF_OTPP:`NFSP_CF_OTPE];

    // Checks on the core domain
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    property p_wel_set;
        cmd_ev && cmd_q.op == `NFSP_OP_WREN |=> sts_q[`NFSP_ST_WEL];
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");

    property p_no_wel;
        cmd_ev && state_q == ST_IDLE && !sts_q[`NFSP_ST_WEL] && cmd_q.op == `NFSP_OP_PROG
            |=> !prog_q && state_q == ST_IDLE;
    endproperty
    a_no_wel: assert property (p_no_wel) else $error("program ran without latch");

    property p_lock_prog;
        cmd_ev && state_q == ST_IDLE && sts_q[`NFSP_ST_WEL] && hit && cmd_q.op == `NFSP_OP_PROG
            |=> sts_q[`NFSP_ST_PFAIL] && !prog_q ##1 !prog_q;
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("locked program not refused");

    property p_lock_erase;
        cmd_ev && state_q == ST_IDLE && sts_q[`NFSP_ST_WEL] && hit && cmd_q.op == `NFSP_OP_ERASE
            |=> sts_q[`NFSP_ST_EFAIL] && !erase_q;
    endproperty
    a_lock_erase: assert property (p_lock_erase) else $error("locked erase not refused");

    property p_busy;
        (prog_q || erase_q || read_q) |-> sts_q[`NFSP_ST_BUSY] && state_q == ST_ARRAY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag low during operation");

    property p_freeze;
        $rose(cfg_q[`NFSP_CF_FREEZE]) |-> $past(prot_q[`NFSP_PR_GUARD_A] & prot_q[`NFSP_PR_GUARD_B]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("freeze set without guard bits");

    property p_frozen;
        cfg_q[`NFSP_CF_FREEZE] && $past(cfg_q[`NFSP_CF_FREEZE]) |-> $stable(prot_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen protection changed");

    property p_no_code;
        cmd_ev && state_q == ST_IDLE && sts_q[`NFSP_ST_WEL] && cmd_q.op == `NFSP_OP_PROG && !bad_row
            && prot_q[`NFSP_PR_CODE_HI:`NFSP_PR_CODE_LO] == 4'h0 |=> prog_q;
    endproperty
    a_no_code: assert property (p_no_code) else $error("zero code blocked a program");

    property p_read_clear;
        cmd_ev && state_q == ST_IDLE && cmd_q.op == `NFSP_OP_READ
            |=> read_q && sts_q[`NFSP_ST_ECC_HI:`NFSP_ST_ECC_LO] == 2'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("result not cleared at read");

    property p_reset_keeps;
        cmd_ev && cmd_q.op == `NFSP_OP_RESET |=> $stable(prot_q) && $stable(cfg_q) ##[1:60] state_q == ST_IDLE;
    endproperty
    a_reset_keeps: assert property (p_reset_keeps) else $error("reset disturbed settings");

    c_prog_ok: cover property (prog_q ##[1:100] (state_q == ST_IDLE));
    c_refused: cover property (cmd_ev && hit && sts_q[`NFSP_ST_WEL]);
    c_freeze:  cover property ($rose(cfg_q[`NFSP_CF_FREEZE]));
endmodule

/* File: dv/nfsp_host_model.sv */
// Host serial controller model on the link pins
// Assumes mode 0: clock parked low between frames
`timescale 1ns/1ps
module nfsp_host_model (
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // Idle bus
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // opcode then address
    // One frame of n bits MSB first; the last 8 bits seen come back in rd
    task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
        cs_n_o = 1'b0;
        #10;
        for (int i = 0; i < n; i++) begin
            mosi_o = bits[39-i];
            #7.5 sck_o = 1'b1;
            rd = {rd[6:0], miso_i};
            #7.5 sck_o = 1'b0;
        end
        #10 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale bit
        #800; // Gap lets the core take the command
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the setting, protection and status logic
// Assumes the host model drives the link; this bench plays the array
`timescale 1ns/1ps
module tb_top;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        arr_done_i = 1'b0;
    logic        arr_fail_i = 1'b0;
    logic [1:0]  arr_ecc_result_i = 2'h0;
    logic        sck, cs_n, mosi, miso, oe, prog, ers, rds, ecc_en, nf, l;
    logic [23:0] row;
    logic [1:0]  otp, ne;
    logic [7:0]  v, es;
    int          n_mismatch = 0, n_compared = 0, n_op = 0, cnt = 0, cyc = 0, n_oe = 0, n, b, p0;
    always #50 clock_i = ~clock_i;
    nfsp_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    nfsp_top i_dut (.clock_i(clock_i), .rst_i(rst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe), .arr_prog_o(prog), .arr_erase_o(ers),
        .arr_read_o(rds), .arr_row_o(row), .arr_ecc_en_o(ecc_en), .otp_mode_o(otp),
        .arr_done_i(arr_done_i), .arr_fail_i(arr_fail_i), .arr_ecc_result_i(arr_ecc_result_i));
    // Array controller: long op so busy can be seen on the link
    always @(negedge clock_i) begin
        arr_done_i <= 1'b0;
        if (prog | ers | rds) begin
            n_op++;
            cnt = 60;
        end else if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                arr_done_i <= 1'b1;
                arr_fail_i <= nf;
                arr_ecc_result_i <= ne;
            end
        end
    end
    // Count link edges at which the device drives its data line
    always @(posedge sck) if (oe === 1'b1) n_oe++;
    // Hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Status is a lagging snapshot, so the second read counts
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        n_oe = 0;
        i_host.xfer({8'h0F, a, 24'h0}, 24, d);
        i_host.xfer({8'h0F, a, 24'h0}, 24, d);
        chk("oe", n_oe, 16);
        chk("oe idle", oe, 1'b0);
    endtask
    task automatic set(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_host.xfer({8'h1F, a, d, 16'h0}, 24, x);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] r, input int k);
        logic [7:0] x;
        i_host.xfer({op, r, 8'h0}, k, x);
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 40; i++) begin
            get(8'hC0, s);
            if (s[0] === 1'b0) break;
        end
    endtask
    // Locked block count per code
    function automatic int sz(input int c);
        return (c == 0) ? 0 : (c > 9) ? 1024 : (1 << c);
    endfunction
    function automatic bit lk(input int c, input bit bot, input int k);
        return bot ? (k < sz(c)) : (k >= 1024 - sz(c));
    endfunction
    // Main sequence
    initial begin
        nf = 1'b0;
        void'($urandom(68296));
        ne = 2'($urandom % 3);
        repeat (6) @(negedge clock_i);
        rst_i = 1'b0;
        es = {2'h0, ne, 4'h0};
        wait_idle();
        chk("boot row", row, 24'h0);
        get(8'hA0, v); chk("prot", v, 8'h7C);
        get(8'hB0, v); chk("cfg", v, 8'h10);
        get(8'hC0, v); chk("sts", v, es);
        chk("ecc en", ecc_en, 1'b1);
        chk("otp", otp, 2'h0);
        cmd(8'h06, 0, 8);
        es[1] = 1'b1;
        get(8'hC0, v); chk("sts", v, es);
        $display("test boot done");
        for (int c = 0; c < 16; c++) begin
            for (int t = 0; t < 8; t++) begin
                n = sz(c);
                b = (t[0] ? (t[2] ? n : n - 1) : (t[2] ? 1023 - n : 1024 - n)) & 1023;
                l = lk(c, t[0], b);
                nf = ($urandom % 4) == 0;
                set(8'hA0, {1'b0, c[3:0], t[0], 2'h0});
                p0 = n_op;
                cmd(t[1] ? 8'hD8 : 8'h10, {8'h0, b[9:0], 6'($urandom % 64)}, 32);
                get(8'hC0, v); chk("busy", v[0], !l);
                wait_idle();
                es[t[1] ? 2 : 3] = l | nf;
                chk("start", n_op - p0, !l);
                get(8'hC0, v); chk("sts", v, es);
            end
        end
        $display("test lock done");
        set(8'hA0, 8'h00);
        cmd(8'h04, 0, 8);
        es[1] = 1'b0;
        p0 = n_op;
        cmd(8'h10, 24'h40, 32);
        es[3] = 1'b0; // Program sequence clears the fail flag even when refused
        wait_idle();
        get(8'hC0, v); chk("sts", v, es);
        chk("start", n_op - p0, 0);
        ne = 2'($urandom % 3);
        es[5:4] = ne;
        nf = 1'b0;
        cmd(8'h13, 24'h80, 32);
        wait_idle();
        get(8'hC0, v); chk("sts", v, es);
        set(8'hB0, 8'h4F); // OTP enable first
        get(8'hB0, v); chk("cfg", v, 8'h40);
        chk("otp", otp, 2'h1);
        chk("ecc en", ecc_en, 1'b0);
        cmd(8'hFF, 0, 8);
        es[5:2] = 4'h0;
        wait_idle();
        get(8'hC0, v); chk("sts", v, es);
        get(8'hB0, v); chk("cfg", v, 8'h40);
        set(8'hB0, 8'h20);
        get(8'hB0, v); chk("cfg", v, 8'h00);
        set(8'hA0, 8'h85);
        set(8'hB0, 8'h20);
        set(8'hA0, 8'h00);
        get(8'hA0, v); chk("prot", v, 8'h85);
        $display("test settings done");
        give_verdict();
    end
endmodule
